// ---- verilog/seia_defs.svh ----
// Overview of operation
// R1: Loader serial clock is system clock divided by 256
// R2: Software may drive and read EEPROM lines directly
// R3: Sense EEPROM presence from pulled-up select line
// R4: Loader reads sixteen-bit words
// R5: Load vendor, model, sub-vendor and product words
// R6: Without EEPROM skip the load, keep working
// R7: EEPROM usable as general storage by software
// R8: Identification valid before host auto-configuration
// R9: Registers occupy 2K block at host base
// R10: Sample infrared strap at every reset kind
// R11: Strap level copied to all four channels
// R12: Software writes override sampled infrared bit
// R13: Device identifier keeps default unless EEPROM loaded
// R14: Per word: select, opcode, address, sixteen bits in
`ifndef SEIA_DEFS_SVH
`define SEIA_DEFS_SVH
`define SEIA_DIV_LAST   8'hFF
`define SEIA_DIV_RISE   8'h80
`define SEIA_CMD_BITS   5'd8
`define SEIA_DATA_BITS  5'd15
`define SEIA_START_BIT  1'b1
`define SEIA_READ_OP    2'b10
`define SEIA_ADDR_PAD   4'h0
`define SEIA_LAST_WORD  2'd3
`define SEIA_W_VENDOR   2'd0
`define SEIA_W_DEVICE   2'd1
`define SEIA_W_SUBVEN   2'd2
`define SEIA_W_SUBSYS   2'd3
`define SEIA_STRAP_WAIT 2'd3
`define SEIA_STRAP_TAKE 2'd1
`define SEIA_BAR_HI     31
`define SEIA_BAR_LO     11
`define SEIA_BAR_ZERO   11'h000
`define SEIA_LOAD_MAX   16'd30000
`endif

// ---- verilog/seia_pkg.sv ----
`default_nettype none
package seia_pkg;
    typedef struct packed {
        logic en;
        logic sck;
        logic cs;
        logic di;
    } seia_man_t;

    typedef struct packed {
        logic [15:0] device;
        logic [15:0] vendor;
        logic [15:0] subsys;
        logic [15:0] subven;
    } seia_id_t;

    typedef enum logic [2:0] {
        st_sense,
        st_sel,
        st_cmd,
        st_data,
        st_gap,
        st_done
    } seia_st_t;
endpackage
`default_nettype wire

// ---- verilog/seia_sync.sv ----
`default_nettype none
module seia_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/seia_top.sv ----
`include "seia_defs.svh"
`default_nettype none
module seia_top #(
    parameter logic [15:0] DEF_VENDOR = 16'h1111, // Arbitrary value
    parameter logic [15:0] DEF_DEVICE = 16'h2222, // Arbitrary value
    parameter logic [15:0] DEF_SUBVEN = 16'h0000,
    parameter logic [15:0] DEF_SUBSYS = 16'h0000
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                soft_rst,
    input  wire seia_pkg::seia_man_t man_ctl,
    output logic                     man_read_data,
    output logic                     eeprom_serial_clock,
    output logic                     eeprom_select_o,
    output logic                     eeprom_select_oe_n,
    input  wire logic                eeprom_select_i,
    output logic                     eeprom_write_line,
    input  wire logic                eeprom_read_line,
    output seia_pkg::seia_id_t       id_words,
    output logic                     id_valid,
    output logic                     eeprom_present,
    input  wire logic                infrared_strap_pin,
    input  wire logic [3:0]          mcr_ir_wr,
    input  wire logic [3:0]          mcr_ir_wdata,
    output logic [3:0]               mcr_ir_mode,
    input  wire logic                bar_wr,
    input  wire logic [31:0]         bar_wdata,
    input  wire logic [31:0]         mem_addr,
    output logic [31:0]              bar_value,
    output logic                     mem_hit
);
    import seia_pkg::*;

    seia_st_t    st_ff;
    logic [7:0]  div_ff;
    logic [1:0]  word_ff;
    logic [4:0]  cnt_ff;
    logic [8:0]  cmd_ff;
    logic [15:0] shin_ff;
    logic [15:0] idw_ff [4];
    logic        present_ff;
    logic [1:0]  pend_ff;
    logic [20:0] bar_ff;
    logic [15:0] load_cnt_ff;
    logic        cs_s;
    logic        rd_s;
    logic        strap_s;
    logic        fall_tick;
    logic        ld_sck;
    logic        ld_cs;
    logic        ld_di;
    logic [15:0] word_in;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    seia_sync u_sync_cs (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (eeprom_select_i),
        .dout    (cs_s)
    );
    seia_sync u_sync_rd (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (eeprom_read_line),
        .dout    (rd_s)
    );
    seia_sync u_sync_ir (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (infrared_strap_pin),
        .dout    (strap_s)
    );

    // Free-running divider; serial clock high in upper half
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_ff <= 8'h00;
        end else if (soft_rst) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01; // [R1]
        end
    end

    assign fall_tick = (div_ff == `SEIA_DIV_LAST);
    assign word_in   = {shin_ff[14:0], rd_s};

    // Loader sequence; bits change and are sampled on falling edges
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff      <= st_sense;
            word_ff    <= 2'd0;
            cnt_ff     <= 5'd0;
            cmd_ff     <= 9'h000;
            shin_ff    <= 16'h0000;
            present_ff <= 1'b0;
        end else if (soft_rst) begin
            st_ff      <= st_sense;
            word_ff    <= 2'd0;
            cnt_ff     <= 5'd0;
            present_ff <= 1'b0;
        end else if (fall_tick) begin
            case (st_ff)
                st_sense: begin
                    present_ff <= cs_s; // [R3]
                    st_ff      <= cs_s ? st_sel : st_done; // [R6]
                end
                st_sel: begin
                    cmd_ff <= {`SEIA_START_BIT, `SEIA_READ_OP, `SEIA_ADDR_PAD, word_ff}; // [R14]
                    cnt_ff <= `SEIA_CMD_BITS;
                    st_ff  <= st_cmd;
                end
                st_cmd: begin
                    if (cnt_ff == 5'd0) begin
                        cnt_ff <= `SEIA_DATA_BITS; // [R4]
                        st_ff  <= st_data;
                    end else begin
                        cmd_ff <= {cmd_ff[7:0], 1'b0}; // [R14]
                        cnt_ff <= cnt_ff - 5'd1;
                    end
                end
                st_data: begin
                    shin_ff <= word_in; // [R4]
                    if (cnt_ff == 5'd0) begin
                        if (word_ff == `SEIA_LAST_WORD) begin
                            st_ff <= st_done;
                        end else begin
                            word_ff <= word_ff + 2'd1; // [R5]
                            st_ff   <= st_gap;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 5'd1;
                    end
                end
                st_gap: begin
                    st_ff <= st_sel;
                end
                st_done: begin
                    st_ff <= st_done;
                end
                default: begin
                    st_ff <= st_done;
                end
            endcase
        end
    end

    // Identification words; defaults stay when nothing is loaded
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idw_ff[`SEIA_W_VENDOR] <= DEF_VENDOR;
            idw_ff[`SEIA_W_DEVICE] <= DEF_DEVICE; // [R13]
            idw_ff[`SEIA_W_SUBVEN] <= DEF_SUBVEN;
            idw_ff[`SEIA_W_SUBSYS] <= DEF_SUBSYS;
        end else if (soft_rst) begin
            idw_ff[`SEIA_W_VENDOR] <= DEF_VENDOR;
            idw_ff[`SEIA_W_DEVICE] <= DEF_DEVICE; // [R13]
            idw_ff[`SEIA_W_SUBVEN] <= DEF_SUBVEN;
            idw_ff[`SEIA_W_SUBSYS] <= DEF_SUBSYS;
        end else if (fall_tick && st_ff == st_data && cnt_ff == 5'd0) begin
            idw_ff[word_ff] <= word_in; // [R5]
        end
    end

    assign id_words.vendor = idw_ff[`SEIA_W_VENDOR];
    assign id_words.device = idw_ff[`SEIA_W_DEVICE];
    assign id_words.subven = idw_ff[`SEIA_W_SUBVEN];
    assign id_words.subsys = idw_ff[`SEIA_W_SUBSYS];
    assign eeprom_present  = present_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            id_valid <= 1'b0;
        end else begin
            id_valid <= (st_ff == st_done) && !soft_rst; // [R8]
        end
    end

    assign ld_sck = ((st_ff == st_cmd) || (st_ff == st_data)) && div_ff[7]; // [R1]
    assign ld_cs  = (st_ff == st_sel) || (st_ff == st_cmd) || (st_ff == st_data);
    assign ld_di  = (st_ff == st_cmd) && cmd_ff[8];

    // Pin drivers; manual control takes the lines from the loader
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eeprom_serial_clock <= 1'b0;
            eeprom_select_o     <= 1'b0;
            eeprom_select_oe_n  <= 1'b1;
            eeprom_write_line   <= 1'b0;
        end else if (man_ctl.en) begin
            eeprom_serial_clock <= man_ctl.sck; // [R2] [R7]
            eeprom_select_o     <= man_ctl.cs;
            eeprom_select_oe_n  <= 1'b0;
            eeprom_write_line   <= man_ctl.di;
        end else begin
            eeprom_serial_clock <= ld_sck;
            eeprom_select_o     <= ld_cs; // [R14]
            eeprom_select_oe_n  <= (st_ff == st_sense); // [R3]
            eeprom_write_line   <= ld_di;
        end
    end

    assign man_read_data = rd_s; // [R2] [R7]

    // Strap capture after reset release once the synchroniser is settled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_ff <= `SEIA_STRAP_WAIT;
        end else if (soft_rst) begin
            pend_ff <= `SEIA_STRAP_WAIT; // [R10]
        end else if (pend_ff != 2'd0) begin
            pend_ff <= pend_ff - 2'd1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mcr_ir_mode <= 4'h0;
        end else if (pend_ff == `SEIA_STRAP_TAKE) begin
            mcr_ir_mode <= {4{strap_s}}; // [R10] [R11]
        end else if (pend_ff == 2'd0) begin
            mcr_ir_mode <= (mcr_ir_mode & ~mcr_ir_wr) | (mcr_ir_wdata & mcr_ir_wr); // [R12]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bar_ff <= 21'h000000;
        end else if (bar_wr) begin
            bar_ff <= bar_wdata[`SEIA_BAR_HI:`SEIA_BAR_LO]; // [R9]
        end
    end

    assign bar_value = {bar_ff, `SEIA_BAR_ZERO};
    assign mem_hit   = (mem_addr[`SEIA_BAR_HI:`SEIA_BAR_LO] == bar_ff); // [R9]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            load_cnt_ff <= 16'h0000;
        end else if (soft_rst) begin
            load_cnt_ff <= 16'h0000;
        end else if (!id_valid && load_cnt_ff != `SEIA_LOAD_MAX) begin
            load_cnt_ff <= load_cnt_ff + 16'h0001;
        end
    end

    sequence s_cmd_rise;
        (st_ff == st_cmd) && $rose(ld_sck) && (cnt_ff != 5'd0);
    endsequence
    sequence s_absent;
        (st_ff == st_sense) && fall_tick && !cs_s && !soft_rst;
    endsequence
    sequence s_data_start;
        (st_ff == st_cmd) ##1 (st_ff == st_data);
    endsequence

    a_sck_rise_pos: assert property ($rose(ld_sck) |-> div_ff == `SEIA_DIV_RISE) // [R1]
        else $error("loader clock rose off divider midpoint");
    a_sck_period: assert property (s_cmd_rise and !soft_rst |-> ##256 $rose(ld_sck)) // [R1]
        else $error("loader clock period is not 256 cycles");
    a_manual_mux: assert property (man_ctl.en |=> eeprom_serial_clock == $past(man_ctl.sck) // [R2]
        && eeprom_select_o == $past(man_ctl.cs) && eeprom_write_line == $past(man_ctl.di)
        && !eeprom_select_oe_n)
        else $error("manual control not passed to pins");
    a_sense_release: assert property ((st_ff == st_sense) && !man_ctl.en |=> eeprom_select_oe_n) // [R3]
        else $error("select line driven during presence sense");
    a_word_bits: assert property (s_data_start |-> cnt_ff == `SEIA_DATA_BITS) // [R4]
        else $error("data phase does not start with sixteen bits");
    a_word_store: assert property (fall_tick && st_ff == st_data && cnt_ff == 5'd0 // [R5]
        && !soft_rst |=> idw_ff[$past(word_ff)] == $past(word_in))
        else $error("assembled word not stored");
    a_absent_skip: assert property (s_absent |=> (st_ff == st_done) ##1 // [R6]
        (id_valid && id_words.device == DEF_DEVICE && !eeprom_present))
        else $error("absent EEPROM did not skip load with defaults");
    a_load_bound: assert property (load_cnt_ff != `SEIA_LOAD_MAX) // [R8]
        else $error("identification load too slow");
    a_bar_write: assert property (bar_wr |=> bar_value[31:11] == $past(bar_wdata[31:11]) // [R9]
        && bar_value[10:0] == 11'h000)
        else $error("base address not held on 2K boundary");
    a_strap_copy: assert property (pend_ff == `SEIA_STRAP_TAKE && !soft_rst // [R11]
        |=> mcr_ir_mode == {4{$past(strap_s)}})
        else $error("strap level not copied to all channels");
    a_strap_soft: assert property (soft_rst ##1 !soft_rst [*3] |-> pend_ff == 2'd1) // [R10]
        else $error("soft reset did not resample strap");
    a_sw_override: assert property (pend_ff == 2'd0 && mcr_ir_wr != 4'h0 // [R12]
        |=> (mcr_ir_mode & $past(mcr_ir_wr)) == ($past(mcr_ir_wdata) & $past(mcr_ir_wr)))
        else $error("software write did not override infrared bit");
    a_cmd_select: assert property ((st_ff == st_cmd) && !man_ctl.en |=> eeprom_select_o) // [R14]
        else $error("select not asserted during command");
    a_cmd_start: assert property ($rose(st_ff == st_cmd) |-> cmd_ff[8] == `SEIA_START_BIT) // [R14]
        else $error("command does not open with start bit");
endmodule
`default_nettype wire

// ---- dv/seia_eeprom_model.sv ----
`default_nettype none
module seia_eeprom_model #(
    parameter logic [63:0] WORDS = 64'h7FFE_8001_5A3C_A5C3
) (
    input  wire logic sclk,
    input  wire logic cs,
    input  wire logic di,
    output logic      dout
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt;
    logic [8:0] cmd;
    logic [15:0] sh;

    initial begin
        cnt  = 0;
        cmd  = 9'h000;
        sh   = 16'h0000;
        dout = 1'b0;
    end

    // Released output shows the inverse of its last value
    always @(negedge cs) begin
        cnt  = 0;
        dout = ~dout;
    end

    always @(posedge sclk) begin
        if (cs) begin
            cnt = cnt + 1;
            if (cnt <= 9) begin
                cmd = {cmd[7:0], di};
            end
            if (cnt == 9 && cmd[8:6] == 3'b110) begin
                sh   = WORDS[16 * cmd[1:0] +: 16];
                dout = 1'b0;
            end else if (cnt > 9 && cnt <= 25 && cmd[8:6] == 3'b110) begin
                dout = sh[15];
                sh   = {sh[14:0], 1'b0};
            end else begin
                dout = ~dout;
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/seia_top_tb.sv ----
`default_nettype none
module seia_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import seia_pkg::*;
    localparam logic [63:0] WORDS = 64'h7FFE_8001_5A3C_A5C3;
    localparam logic [15:0] D_VEN = 16'h1111; // Arbitrary value
    localparam logic [15:0] D_DEV = 16'h2222; // Arbitrary value
    logic        clk_sys, rst, soft_rst, man_read_data, eeprom_serial_clock;
    logic        eeprom_select_o, eeprom_select_oe_n, eeprom_select_i, eeprom_write_line;
    logic        eeprom_read_line, id_valid, eeprom_present, infrared_strap_pin, fitted;
    logic        bar_wr, mem_hit;
    logic [3:0]  mcr_ir_wr, mcr_ir_wdata, mcr_ir_mode;
    logic [31:0] bar_wdata, mem_addr, bar_value;
    seia_man_t   man_ctl;
    seia_id_t    id_words;
    int          n_errors, checks;

    assign eeprom_select_i = !eeprom_select_oe_n ? eeprom_select_o : fitted;

    seia_top #(.DEF_VENDOR(D_VEN), .DEF_DEVICE(D_DEV), .DEF_SUBVEN(16'h0000),
               .DEF_SUBSYS(16'h0000)) dut (
        .clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .man_ctl(man_ctl),
        .man_read_data(man_read_data), .eeprom_serial_clock(eeprom_serial_clock),
        .eeprom_select_o(eeprom_select_o), .eeprom_select_oe_n(eeprom_select_oe_n),
        .eeprom_select_i(eeprom_select_i), .eeprom_write_line(eeprom_write_line),
        .eeprom_read_line(eeprom_read_line), .id_words(id_words), .id_valid(id_valid),
        .eeprom_present(eeprom_present), .infrared_strap_pin(infrared_strap_pin),
        .mcr_ir_wr(mcr_ir_wr), .mcr_ir_wdata(mcr_ir_wdata), .mcr_ir_mode(mcr_ir_mode),
        .bar_wr(bar_wr), .bar_wdata(bar_wdata), .mem_addr(mem_addr),
        .bar_value(bar_value), .mem_hit(mem_hit));

    seia_eeprom_model #(.WORDS(WORDS)) u_eeprom (
        .sclk(eeprom_serial_clock), .cs(eeprom_select_i),
        .di(eeprom_write_line), .dout(eeprom_read_line));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input logic fit, input logic strap);
        @(negedge clk_sys);
        rst                = 1'b1;
        fitted             = fit;
        infrared_strap_pin = strap;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        while (id_valid !== 1'b1 && n < 30000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 30000) begin
            n_errors++;
            $display("[FAIL] %0t load never finished", $time);
            close_out();
        end
    endtask

    task automatic wait_sck_rise(output int n);
        n = 0;
        while (eeprom_serial_clock !== 1'b0 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n < 2000) begin
            n = 0;
            while (eeprom_serial_clock !== 1'b1 && n < 2000) begin
                @(negedge clk_sys);
                n++;
            end
        end
        if (n >= 2000) begin
            n_errors++;
            $display("[FAIL] %0t loader clock stalled", $time);
            close_out();
        end
    endtask

    task automatic t_load_present();
        int a, b;
        do_reset(1'b1, 1'b1);
        wait_sck_rise(a);
        wait_sck_rise(a);
        wait_sck_rise(b);
        chk(64'(a + 0), 64'(256 - 128), "loader clock low phase");
        chk(64'(b), 64'h80, "loader clock low phase again");
        chk(64'(eeprom_present), 64'h1, "presence sensed");
        wait_valid();
        chk(id_words, {WORDS[31:16], WORDS[15:0], WORDS[63:48], WORDS[47:32]}, "ids loaded");
        chk(64'(mcr_ir_mode), 64'hF, "strap copied");
        $display("load with eeprom done");
    endtask

    task automatic t_override();
        @(negedge clk_sys);
        mcr_ir_wr    = 4'b0101;
        mcr_ir_wdata = 4'b0000;
        @(negedge clk_sys);
        mcr_ir_wr    = 4'b0000;
        @(negedge clk_sys);
        chk(64'(mcr_ir_mode), 64'hA, "infrared override");
        $display("override done");
    endtask

    task automatic mbit(input logic d, output logic q);
        @(negedge clk_sys);
        man_ctl.sck = 1'b0;
        man_ctl.di  = d;
        repeat (4) @(negedge clk_sys);
        man_ctl.sck = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk(64'(eeprom_serial_clock), 64'h1, "manual clock");
        q = man_read_data;
    endtask

    task automatic t_manual();
        logic [8:0]  cmd;
        logic [15:0] got;
        logic        q;
        cmd = 9'b1_10_000010;
        @(negedge clk_sys);
        man_ctl = '{en: 1'b1, sck: 1'b0, cs: 1'b1, di: 1'b0};
        repeat (4) @(negedge clk_sys);
        chk(64'({eeprom_select_o, eeprom_select_oe_n}), 64'h2, "manual select");
        for (int i = 8; i >= 0; i--) begin
            mbit(cmd[i], q);
        end
        for (int i = 15; i >= 0; i--) begin
            mbit(1'b0, q);
            got[i] = q;
        end
        chk(64'(got), 64'(WORDS[47:32]), "manual word read");
        @(negedge clk_sys);
        man_ctl = '{en: 1'b0, sck: 1'b0, cs: 1'b0, di: 1'b0};
        $display("manual access done");
    endtask

    task automatic t_bar();
        @(negedge clk_sys);
        bar_wr    = 1'b1;
        bar_wdata = 32'hABCD_E123;
        @(negedge clk_sys);
        bar_wr = 1'b0;
        chk(64'(bar_value), 64'hABCD_E000, "base kept");
        mem_addr = 32'hABCD_E7FF;
        #1 chk(64'(mem_hit), 64'h1, "top of window");
        mem_addr = 32'hABCD_E800;
        #1 chk(64'(mem_hit), 64'h0, "past window");
        $display("base address done");
    endtask

    task automatic t_soft();
        @(negedge clk_sys);
        infrared_strap_pin = 1'b0;
        soft_rst           = 1'b1;
        @(negedge clk_sys);
        soft_rst = 1'b0;
        @(negedge clk_sys);
        chk(64'(id_valid), 64'h0, "valid dropped");
        wait_valid();
        chk(64'(mcr_ir_mode), 64'h0, "strap resampled");
        chk(id_words, {WORDS[31:16], WORDS[15:0], WORDS[63:48], WORDS[47:32]}, "reload");
        $display("soft reset done");
    endtask

    task automatic t_absent();
        do_reset(1'b0, 1'b1);
        wait_valid();
        chk(64'(eeprom_present), 64'h0, "absence sensed");
        chk(id_words, {D_DEV, D_VEN, 32'h0000_0000}, "default ids");
        chk(64'(mcr_ir_mode), 64'hF, "strap after reset");
        $display("no eeprom done");
    endtask

    initial begin
        n_errors           = 0;
        checks             = 0;
        rst                = 1'b1;
        fitted             = 1'b1;
        soft_rst           = 1'b0;
        infrared_strap_pin = 1'b0;
        man_ctl            = '{en: 1'b0, sck: 1'b0, cs: 1'b0, di: 1'b0};
        mcr_ir_wr          = 4'h0;
        mcr_ir_wdata       = 4'h0;
        bar_wr             = 1'b0;
        bar_wdata          = 32'h0000_0000;
        mem_addr           = 32'h0000_0000;
        t_load_present();
        t_override();
        t_manual();
        t_bar();
        t_soft();
        t_absent();
        close_out();
    end
endmodule
`default_nettype wire
